// ===== core/spimsp_regs.svh
//----------------------------------------------------------------------
// spimsp register map, field positions, reset values and timing counts
//----------------------------------------------------------------------
// holds definitions only; included by the port core
// assumes a 32-bit avalon-mm slave with byte addresses, one word per register
`ifndef SPIMSP_REGS_SVH
`define SPIMSP_REGS_SVH

// ---------------------------------------------------------------------
// byte offsets
// ---------------------------------------------------------------------
`define SPIMSP_CTRL_OFS 4'h0
`define SPIMSP_STAT_OFS 4'h4
`define SPIMSP_DATA_OFS 4'h8

// ---------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------
`define SPIMSP_STAT_DONE_BIT 7
`define SPIMSP_STAT_WRITE_COLLISION_FLAG_BIT 6
`define SPIMSP_STAT_MODE_FAULT_FLAG_BIT 4

// ---------------------------------------------------------------------
// reset values and counts
// ---------------------------------------------------------------------
`define SPIMSP_CTRL_RST 8'h14
`define SPIMSP_LAST_EDGE 4'hf
`define SPIMSP_RATE_NONE0 3'h0
`define SPIMSP_RATE_NONE7 3'h7

`endif

// ===== core/spimsp_pkg.sv
// spimsp shared types: control layout and master sequencer states
// assumes the register header supplies the register constants; the state encodings are set here
package spimsp_pkg;

  // control register, bit 7 down to bit 0
  typedef struct packed {
    logic rateHi;   // rate_select_hi
    logic en;       // port_enable
    logic select_pin_disable;    // select_pin_disable
    logic master_select;     // master_select
    logic clock_idle_level;     // clock_idle_level
    logic clock_sample_phase;     // clock_sample_phase
    logic rateMid;  // rate_select_mid
    logic rateLo;   // rate_select_lo
  } spimsp_ctrl_s;

  // master sequencer
  typedef enum logic [1:0] {
    MS_IDLE = 2'b01,
    MS_RUN = 2'b10
  } spimsp_mstate_e;

endpackage

// ===== core/spimsp_sync.sv
// spimsp two-stage synchroniser for pin inputs
// assumes inputs are asynchronous to clk; only stage two is read outside
`timescale 1ns/10ps
module spimsp_sync #(
  parameter int W = 4
) (
  input wire logic clk,         // system clock
  input wire logic rst,         // async reset, high
  input wire logic [W-1:0] d,   // raw pin levels
  output logic [W-1:0] q        // synchronised levels
);
  logic [W-1:0] meta_q; // first stage, read only by q

  // two flops in series, reset to idle-high pin levels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= {W{1'b1}};
      q <= {W{1'b1}};
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ===== core/spimsp_core.sv
// spimsp serial port core: master/slave byte exchange with avalon-mm registers
// assumes pins are asynchronous and are synchronised here before use
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`include "spimsp_regs.svh"
`timescale 1ns/10ps
module spimsp_core (
  input wire logic clk,                 // 50 mhz system clock
  input wire logic rst,                 // async reset, high
  input wire logic [3:0] avs_address,   // byte address
  input wire logic avs_read,            // read request
  input wire logic avs_write,           // write request
  input wire logic [31:0] avs_writedata, // write data
  output logic [31:0] avs_readdata,     // read data, registered
  output logic avs_waitrequest,         // stall
  input wire logic sckIn,               // serial clock pin level
  output logic sckOut,                  // serial clock drive value
  output logic sckOe,                   // serial clock drive enable
  input wire logic mosiIn,              // mosi pin level
  output logic mosiOut,                 // mosi drive value
  output logic mosiOe,                  // mosi drive enable
  input wire logic misoIn,              // miso pin level
  output logic misoOut,                 // miso drive value
  output logic misoOe,                  // miso drive enable
  input wire logic ssInN,               // slave select pin, low active
  output logic txIrq,                   // transmitter request level
  output logic rxErrIrq                 // receiver/error request level
);

  // ------------------------------------------------------------------
  // pin synchronisation and edge detection
  // ------------------------------------------------------------------
  logic [3:0] pinS;     // synchronised sck, mosi, miso, ss
  logic sckS;           // synced clock pin
  logic mosiS;          // synced mosi
  logic misoS;          // synced miso
  logic ssS;            // synced select, low active
  logic sckP_q;         // previous synced clock
  logic ssP_q;          // previous synced select

  spimsp_sync #(.W(4)) uSync (
    .clk(clk),
    .rst(rst),
    .d({sckIn, mosiIn, misoIn, ssInN}),
    .q(pinS)
  );

  assign sckS = pinS[3];
  assign mosiS = pinS[2];
  assign misoS = pinS[1];
  assign ssS = pinS[0];

  // history for edge finding
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sckP_q <= 1'b1;
      ssP_q <= 1'b1;
    end else begin
      sckP_q <= sckS;
      ssP_q <= ssS;
    end
  end

  // ------------------------------------------------------------------
  // register state
  // ------------------------------------------------------------------
  spimsp_pkg::spimsp_ctrl_s ctrl_q;  // control register
  spimsp_pkg::spimsp_ctrl_s ctrl_d;  // control next value
  spimsp_pkg::spimsp_mstate_e mst_q; // master sequencer state
  spimsp_pkg::spimsp_mstate_e mst_d; // master sequencer next
  logic doneFlag_q;   // transfer_done_flag
  logic wcolFlag_q;   // write_collision_flag
  logic modfFlag_q;   // mode_fault_flag
  logic doneArm_q;    // status read seen with done set
  logic wcolArm_q;    // status access seen with collision set
  logic modfArm_q;    // status read seen with fault set
  logic [7:0] rx_q;   // receive buffer
  logic [7:0] sh_q;   // shift register
  logic outBit_q;     // serial output bit
  logic [3:0] edge_q; // clock edge index within byte
  logic [6:0] div_q;  // half-period counter
  logic sck_q;        // master clock level
  logic armed_q;      // phase-zero slave armed by select fall
  logic ack_q;        // second cycle of a bus access
  logic smpDly_q;     // master sample, one cycle late
  logic lastDly_q;    // master last edge, one cycle late

  // ------------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------------
  // half-period length minus one for a rate code, 2^code cycles
  function automatic logic [6:0] halfLim(input logic [2:0] code);
    logic [7:0] one;
    one = 8'h01 << code;
    return 7'(one - 8'h01);
  endfunction

  // rate codes that drive a clock; codes 0 and 7 drive none
  function automatic logic rateOk(input logic [2:0] code);
    return (code != `SPIMSP_RATE_NONE0) && (code != `SPIMSP_RATE_NONE7);
  endfunction

  wire [2:0] rateCode = {ctrl_q.rateHi, ctrl_q.rateMid, ctrl_q.rateLo}; // rate select
  wire en = ctrl_q.en;        // port enabled
  wire isMst = ctrl_q.master_select;   // master role
  wire clock_sample_phase = ctrl_q.clock_sample_phase;    // sample phase

  // ------------------------------------------------------------------
  // avalon slave decode: one wait cycle, then accept
  // ------------------------------------------------------------------
  wire req = avs_read | avs_write;       // request present
  wire acc = req & ack_q;                // accepted this edge
  wire selCtrl = avs_address == `SPIMSP_CTRL_OFS; // control hit
  wire selStat = avs_address == `SPIMSP_STAT_OFS; // status hit
  wire selData = avs_address == `SPIMSP_DATA_OFS; // data hit
  wire ctrlWr = acc & avs_write & selCtrl;        // control write
  wire statRd = acc & avs_read & selStat;         // status read
  wire statAcc = acc & selStat;                   // any status access
  wire dataRd = acc & avs_read & selData;         // data read
  wire dataWr = acc & avs_write & selData;        // data write
  wire dataAcc = acc & selData;                   // any data access

  assign avs_waitrequest = req & ~ack_q;

  wire [7:0] statByte = {doneFlag_q, wcolFlag_q, 1'b0, modfFlag_q, 4'h0}; // status image
  wire [7:0] rdByte = selCtrl ? ctrl_q : selStat ? statByte : selData ? rx_q : 8'h00; // mux

  // bus handshake and registered read data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      ack_q <= req & ~ack_q;
      if (avs_read & ~ack_q) begin
        avs_readdata <= {24'h0, rdByte};
      end
    end
  end

  // ------------------------------------------------------------------
  // shift engine, shared by master and slave
  // ------------------------------------------------------------------
  wire slvSel = ~ssS | (clock_sample_phase & ctrl_q.select_pin_disable);     // slave selected
  wire slvAct = en & ~isMst & slvSel;             // slave may shift
  wire ssFall = ssP_q & ~ssS;                     // select falling
  wire slvArmed = clock_sample_phase | armed_q;                 // phase one needs no select edge
  wire sEdge = slvAct & slvArmed & (sckS != sckP_q); // slave clock edge
  wire mTick = (mst_q == spimsp_pkg::MS_RUN) & (div_q == halfLim(rateCode)); // master edge
  wire sckEdge = isMst ? mTick : sEdge;           // active edge of either role
  wire sampleEdge = sckEdge & (edge_q[0] == clock_sample_phase); // phase selects sample edges
  wire shiftEdge = sckEdge & (edge_q[0] != clock_sample_phase);  // remaining edges shift out
  wire inBit = isMst ? misoS : mosiS;             // master reads miso
  wire smpNow = isMst ? smpDly_q : sampleEdge;    // master waits out miso sync
  wire [7:0] shNext = smpNow ? {sh_q[6:0], inBit} : sh_q; // msb first
  wire done = isMst ? lastDly_q : sckEdge & (edge_q == `SPIMSP_LAST_EDGE);
  wire busy = isMst ? (mst_q == spimsp_pkg::MS_RUN) : (edge_q != 4'h0); // transfer on
  wire modfSet = en & isMst & ~ctrl_q.select_pin_disable & ~ssS; // select low in master
  wire idleWr = dataWr & ~busy;                   // write loads shift register
  wire mStart = idleWr & en & isMst & rateOk(rateCode); // master kick-off
  wire slvDrop = ~slvAct;                         // deselect aborts slave byte

  // master sequencer
  always_comb begin
    mst_d = mst_q;
    case (mst_q)
      spimsp_pkg::MS_IDLE: begin
        if (mStart) begin
          mst_d = spimsp_pkg::MS_RUN;
        end
      end
      spimsp_pkg::MS_RUN: begin
        if (done | modfSet | ~en | ~isMst) begin
          mst_d = spimsp_pkg::MS_IDLE;
        end
      end
      default: mst_d = spimsp_pkg::MS_IDLE;
    endcase
  end

  // sequencer, divider and master clock level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mst_q <= spimsp_pkg::MS_IDLE;
      div_q <= 7'h0;
      sck_q <= 1'b0;
    end else begin
      mst_q <= mst_d;
      div_q <= (mst_q != spimsp_pkg::MS_RUN | mTick) ? 7'h0 : 7'(div_q + 7'h1);
      if (mst_d != spimsp_pkg::MS_RUN) begin
        sck_q <= ctrl_d.clock_idle_level;           // idle level, follows a control write
      end else if (mTick) begin
        sck_q <= ~sck_q;                // divided clock
      end
    end
  end

  // master sample and end strobes, one cycle late to cover the miso sync lag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      smpDly_q <= 1'b0;
      lastDly_q <= 1'b0;
    end else begin
      smpDly_q <= isMst & sampleEdge;
      lastDly_q <= isMst & mTick & (edge_q == `SPIMSP_LAST_EDGE);
    end
  end

  // edge index: cleared on start, abort or deselect
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      edge_q <= 4'h0;
    end else if (mStart | (isMst & mst_q != spimsp_pkg::MS_RUN) | (~isMst & slvDrop)) begin
      edge_q <= 4'h0;
    end else if (sckEdge) begin
      edge_q <= 4'(edge_q + 4'h1);
    end
  end

  // phase-zero slave: select fall arms one byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      armed_q <= 1'b0;
    end else if (slvDrop | done) begin
      armed_q <= 1'b0;
    end else if (ssFall) begin
      armed_q <= 1'b1;
    end
  end

  // shift register and output bit; busy writes leave them alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_q <= 8'h0;
      outBit_q <= 1'b0;
    end else if (idleWr) begin
      sh_q <= avs_writedata[7:0];
      outBit_q <= avs_writedata[7];     // phase zero drives msb early
    end else begin
      sh_q <= shNext;
      if (shiftEdge) begin
        outBit_q <= sh_q[7];            // msb first out
      end
    end
  end

  // ------------------------------------------------------------------
  // flags, receive buffer and control register
  // ------------------------------------------------------------------
  wire doneClr = doneArm_q & dataRd;      // status read then data read
  wire wcolClr = wcolArm_q & dataAcc;     // status then data access
  wire modfClr = modfArm_q & ctrlWr;      // status read then control write
  wire wcolSet = dataWr & busy;           // write during a transfer

  // receive buffer loads only while the flag is clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_q <= 8'h0;
    end else if (done & ~doneFlag_q) begin
      rx_q <= shNext;                   // copy with flag set
    end
  end

  // sticky flags; set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      doneFlag_q <= 1'b0;
      wcolFlag_q <= 1'b0;
      modfFlag_q <= 1'b0;
    end else begin
      doneFlag_q <= done | (doneFlag_q & ~doneClr);
      wcolFlag_q <= wcolSet | (wcolFlag_q & ~wcolClr);
      modfFlag_q <= modfSet | (modfFlag_q & ~modfClr);
    end
  end

  // clearing-sequence arms, dropped once used
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      doneArm_q <= 1'b0;
      wcolArm_q <= 1'b0;
      modfArm_q <= 1'b0;
    end else begin
      doneArm_q <= (statRd & doneFlag_q) | (doneArm_q & ~dataRd);
      wcolArm_q <= (statAcc & wcolFlag_q) | (wcolArm_q & ~dataAcc);
      modfArm_q <= (statRd & modfFlag_q) | (modfArm_q & ~ctrlWr);
    end
  end

  // control next value: a fault overrides enable and role
  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrlWr) begin
      ctrl_d = avs_writedata[7:0];
    end
    if (modfSet) begin
      ctrl_d.en = 1'b0;                 // disable port
      ctrl_d.master_select = 1'b0;               // drop master role
    end
  end

  // control register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `SPIMSP_CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ------------------------------------------------------------------
  // pins and requests
  // ------------------------------------------------------------------
  wire mDrive = en & isMst;                        // master owns sck and mosi
  assign sckOut = mDrive ? sck_q : ctrl_q.clock_idle_level;    // idle level when parked
  assign sckOe = mDrive;
  assign mosiOut = outBit_q;
  assign mosiOe = mDrive;
  assign misoOut = outBit_q;
  assign misoOe = slvAct;                          // float when deselected
  assign txIrq = doneFlag_q;
  assign rxErrIrq = modfFlag_q & ~ctrl_q.select_pin_disable;    // gated by pin disable

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence doneSeen_s;
    doneFlag_q && statRd;
  endsequence

  sequence dataRead_s;
    dataRd && !done;
  endsequence

  done_sets_flag_a: assert property (done |=> doneFlag_q && txIrq)
    else $error("done flag not set after last edge");

  rx_copy_a: assert property (done && !doneFlag_q |=> rx_q == $past(shNext))
    else $error("receive buffer missed the finished byte");

  rx_keep_a: assert property (doneFlag_q && !doneClr |=> rx_q == $past(rx_q))
    else $error("receive buffer overwritten while flag set");

  done_clear_a: assert property (doneSeen_s ##[2:8] dataRead_s |=> !doneFlag_q)
    else $error("done flag survived its clearing sequence");

  fault_disable_a: assert property (modfSet |=> !ctrl_q.en && !ctrl_q.master_select && modfFlag_q)
    else $error("mode fault did not disable the port");

  fault_irq_gate_a: assert property (ctrl_q.select_pin_disable |-> !rxErrIrq)
    else $error("fault request with pin disable set");

  write_collision_flag_busy_a: assert property (dataWr && busy |=> wcolFlag_q && sh_q == $past(shNext))
    else $error("busy write not flagged or disturbed shift");

  miso_float_a: assert property (ssS && !(clock_sample_phase && ctrl_q.select_pin_disable) |-> !misoOe)
    else $error("miso driven while deselected");

  sck_idle_a: assert property (mDrive && !busy |-> sckOut == ctrl_q.clock_idle_level)
    else $error("master clock not at idle level");

  start_run_a: assert property (mStart |=> busy ##1 (sckOut == ctrl_q.clock_idle_level))
    else $error("data write did not start a master transfer");

endmodule

// ===== dv/spimsp_slave_model.sv
// behavioural serial slave that sits on the far side of the port in master mode
// assumes the bench works out the wire levels and drives select and format
`timescale 1ns/10ps
module spimsp_slave_model (
  input wire logic sck,          // serial clock wire
  input wire logic mosi,         // data from the master
  input wire logic selN,         // select, low active
  input wire logic clock_idle_level,         // idle level of sck
  input wire logic clock_sample_phase,         // sample phase
  input wire logic [7:0] txByte, // byte returned to the master
  output logic miso,             // data to the master
  output logic [7:0] rxByte      // byte taken in
);
  logic [7:0] shq; // outgoing shift register
  logic outQ;      // bit now on the line
  logic leadE;     // edge leaves the idle level

  initial outQ = 1'b0;

  // released line shows the inverse of the last bit, never a stale copy
  assign miso = selN ? ~outQ : outQ;

  // select fall loads the byte; phase zero puts the msb out before the first edge
  always @(negedge selN) begin
    shq = txByte;
    rxByte = 8'h00;
    if (!clock_sample_phase) begin
      outQ = shq[7];
      shq = {shq[6:0], 1'b0};
    end
  end

  // phase zero samples on leading edges, phase one shifts on them
  always @(sck) begin
    if (!selN) begin
      leadE = (sck != clock_idle_level);
      if (leadE == clock_sample_phase) begin
        outQ = shq[7];
        shq = {shq[6:0], 1'b0};
      end else begin
        rxByte = {rxByte[6:0], mosi};
      end
    end
  end
endmodule

// ===== dv/testbench.sv
// self-checking bench for the serial port core in master and slave mode
// assumes avalon-mm with one wait state and a slave model on the link
`timescale 1ns/10ps
module testbench;
  logic clk, rst, avs_read, avs_write, avs_waitrequest, ssInN; // bus and control
  logic [3:0] avs_address;                 // byte address
  logic [31:0] avs_writedata, avs_readdata; // bus data
  logic sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, txIrq, rxErrIrq; // pins
  logic slvMiso, slvSelN, curCpol, curCpha, extTgl, extMosi; // partner side, bench master
  logic [7:0] slvTx, slvRx;                 // partner bytes
  wire sckW = (sckOe === 1'b1) ? sckOut : curCpol ^ extTgl; // idle level or bench clock
  wire mosiW = (mosiOe === 1'b1) ? mosiOut : extMosi;      // bench data, idles high
  wire misoW = (misoOe === 1'b1) ? misoOut : slvMiso; // slave drives otherwise
  logic [7:0] expQ[$]; // expected read data
  int n_mismatch, cmp_count, edgeCnt, cyc;

  spimsp_core DUT (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sckIn(sckW), .sckOut(sckOut), .sckOe(sckOe),
    .mosiIn(mosiW), .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoW), .misoOut(misoOut),
    .misoOe(misoOe), .ssInN(ssInN), .txIrq(txIrq), .rxErrIrq(rxErrIrq));
  spimsp_slave_model partner (.sck(sckW), .mosi(mosiW), .selN(slvSelN), .clock_idle_level(curCpol),
    .clock_sample_phase(curCpha), .txByte(slvTx), .miso(slvMiso), .rxByte(slvRx));

  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  // counts driven clock edges of one transfer
  always @(sckW) if (sckOe === 1'b1) edgeCnt++;

  task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  // accepted reads: oldest note against the data standing at the accepting edge
  always @(posedge clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && expQ.size() > 0)
      cmp("readdata", expQ.pop_front(), avs_readdata[7:0]);
  end

  // one bus access; held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                     input logic [7:0] e);
    int k;
    @(posedge clk);
    avs_address <= a;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= {24'h0, d};
    if (!wr) expQ.push_back(e);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (avs_waitrequest !== 1'b0) cmp("waitrequest", 8'h00, 8'h01);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // one master byte against the slave model
  task automatic xfer(input logic [7:0] txB, input logic [7:0] rxB, input bit coll, input int h);
    int k, t0;
    slvTx <= rxB;
    slvSelN <= 1'b0;
    repeat (4) @(posedge clk);
    edgeCnt = 0;
    bus(1'b1, 4'h8, txB, 8'h00);
    t0 = cyc;
    if (coll) bus(1'b1, 4'h8, ~txB, 8'h00);
    for (k = 0; k < 3000 && !(edgeCnt == 16 && txIrq === 1'b1); k++) @(posedge clk);
    cmp("txIrq", 8'h01, {7'h0, txIrq});
    cmp("sck edges", 8'd16, edgeCnt[7:0]);
    cmp("rate ok", 8'h01, {7'h0, (cyc - t0 >= 16 * h) && (cyc - t0 <= 16 * h + 12)});
    cmp("mosi byte", txB, slvRx);
    slvSelN <= 1'b1;
    @(posedge clk);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    #1500000;
    n_mismatch++;
    summarize();
  end

  initial begin
    logic [7:0] ctl, txB, rxB, sMiso;
    clk = 0; rst = 1; avs_read = 0; avs_write = 0; avs_address = 0; avs_writedata = 0;
    ssInN = 1; slvSelN = 1; curCpol = 0; curCpha = 0; slvTx = 0; extTgl = 0; extMosi = 1;
    void'($urandom(32'h8cd7ef4c));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, 4'h0, 8'h00, 8'h14);
    bus(1'b0, 4'h4, 8'h00, 8'h00);
    bus(1'b0, 4'hc, 8'h00, 8'h00);
    // disabled port ignores a data write
    bus(1'b1, 4'h0, 8'h11, 8'h00);
    bus(1'b1, 4'h8, 8'ha5, 8'h00);
    repeat (100) @(posedge clk);
    cmp("txIrq", 8'h00, {7'h0, txIrq});
    bus(1'b0, 4'h4, 8'h00, 8'h00);
    // every clocking rate code, 1 to 6, all four formats
    for (int i = 1; i <= 6; i++) begin
      ctl = {i[2], 1'b0, 1'b0, 1'b1, i[1], i[0], i[1], i[0]};
      bus(1'b1, 4'h0, ctl, 8'h00);
      curCpol <= i[1];
      curCpha <= i[0];
      bus(1'b1, 4'h0, ctl | 8'h40, 8'h00);
      repeat (4) @(posedge clk);
      cmp("sck idle", {7'h0, i[1]}, {7'h0, sckW});
      txB = 8'($urandom);
      rxB = 8'($urandom);
      xfer(txB, rxB, i == 2, 1 << i);
      bus(1'b0, 4'h4, 8'h00, (i == 2) ? 8'hc0 : 8'h80);
      bus(1'b0, 4'h8, 8'h00, rxB);
      bus(1'b0, 4'h4, 8'h00, 8'h00);
      cmp("txIrq", 8'h00, {7'h0, txIrq});
    end
    // second byte before the flag is cleared is dropped
    bus(1'b1, 4'h0, 8'h01, 8'h00);
    curCpol <= 1'b0;
    curCpha <= 1'b0;
    bus(1'b1, 4'h0, 8'h51, 8'h00);
    rxB = 8'($urandom);
    xfer(8'($urandom), rxB, 1'b0, 2);
    xfer(8'($urandom), ~rxB, 1'b0, 2);
    bus(1'b0, 4'h4, 8'h00, 8'h80);
    bus(1'b0, 4'h8, 8'h00, rxB);
    bus(1'b0, 4'h4, 8'h00, 8'h00);
    // select low in master mode
    ssInN <= 1'b0;
    for (int k = 0; k < 20 && rxErrIrq !== 1'b1; k++) @(posedge clk);
    cmp("rxErrIrq", 8'h01, {7'h0, rxErrIrq});
    ssInN <= 1'b1;
    bus(1'b0, 4'h0, 8'h00, 8'h01);
    bus(1'b0, 4'h4, 8'h00, 8'h10);
    bus(1'b1, 4'h0, 8'h11, 8'h00);
    bus(1'b0, 4'h4, 8'h00, 8'h00);
    cmp("rxErrIrq", 8'h00, {7'h0, rxErrIrq});
    // pin disabled: no fault at all
    bus(1'b1, 4'h0, 8'h71, 8'h00);
    ssInN <= 1'b0;
    repeat (20) @(posedge clk);
    cmp("rxErrIrq", 8'h00, {7'h0, rxErrIrq});
    bus(1'b0, 4'h4, 8'h00, 8'h00);
    bus(1'b0, 4'h0, 8'h00, 8'h71);
    ssInN <= 1'b1;
    // slave role, phase one: the bench plays the master with a 160 ns link clock
    bus(1'b1, 4'h0, 8'h04, 8'h00);
    bus(1'b1, 4'h0, 8'h44, 8'h00);
    txB = 8'($urandom);
    rxB = 8'($urandom);
    bus(1'b1, 4'h8, txB, 8'h00);
    ssInN <= 1'b0;
    repeat (8) @(posedge clk);
    for (int b = 7; b >= 0; b--) begin
      extTgl <= 1'b1;
      extMosi <= rxB[b];
      repeat (4) @(posedge clk);
      sMiso[b] = misoW;
      extTgl <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (8) @(posedge clk);
    cmp("miso byte", txB, sMiso);
    cmp("txIrq", 8'h01, {7'h0, txIrq});
    ssInN <= 1'b1;
    repeat (4) @(posedge clk);
    cmp("misoOe", 8'h00, {7'h0, misoOe});
    bus(1'b0, 4'h4, 8'h00, 8'h80);
    bus(1'b0, 4'h8, 8'h00, rxB);
    repeat (4) @(posedge clk);
    summarize();
  end
endmodule
